// [hw/cfc_framer.v]
`timescale 1ns/1ps
`default_nettype none
`include "cfc_regs.vh"
// Behaviour
// - six zero preamble bytes, then sync B2h 4Dh, at 212/424; a start bit instead at 106
// - length byte counts data plus itself
// - crc over length and data, msb first
// - crc two bytes appended after last data at 212/424, none at 106
// - crc preset to zero per frame
// - 106 uses type A, 212/424 manchester
// - speed fixed throughout a transaction
// - reset: target role, own field off
// - level detector enabled while target
// - initiator field after quiet idle-detect time
// - target answers passive load or active field
// - decode modified miller downlink at all speeds
// - type A card: subcarrier manchester or bpsk
// - manchester-scheme card: manchester load modulation
module cfc_framer (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // host frame bytes, length byte first
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_last,
  output reg tx_ready_ff,
  // mode control
  input wire [1:0] speed_sel,
  input wire card_mode,
  input wire card_type_a,
  input wire active_mode,
  input wire init_req,
  // rf front end pins
  input wire carrier_in,
  input wire ext_field_in,
  input wire rx_pause_in,
  output reg field_on_ff,
  output reg field_mod_ff,
  output reg load_mod_ff,
  output reg level_det_en_ff,
  output reg initiator_ff,
  output reg tx_busy_ff,
  // decoded downlink bits
  output reg rx_bit_ff,
  output reg rx_bit_valid_ff,
  output reg rx_active_ff
);
  localparam integer IDLE_CYC = `CFC_IDLE_DETECT_CYC;
  localparam [9:0] IDLE_LIM = IDLE_CYC[9:0] - 10'h001;

  reg [2:0] car_sync_ff;
  reg [2:0] pause_sync_ff;
  reg [1:0] ext_sync_ff;
  reg [2:0] state_ff;
  reg [3:0] cnt_ff;
  reg [8:0] sh_ff;
  reg [3:0] bits_ff;
  reg [7:0] nb_ff;
  reg nb_valid_ff;
  reg last_ff;
  reg [1:0] spd_ff;
  reg [6:0] hcnt_ff;
  reg half_ff;
  reg prev_ff;
  reg [2:0] sc_cnt_ff;
  reg sc_ff;
  reg [9:0] idle_cnt_ff;
  reg init_field_ff;
  reg [7:0] rx_cnt_ff;
  reg rx_sof_ff;
  reg rx_seen1_ff;
  reg rx_seen2_ff;
  reg rx_prev_ff;
  reg [2:0] nxt_state;
  reg [3:0] nxt_cnt;
  reg [8:0] nxt_sh;
  reg [3:0] nxt_bits;
  reg [7:0] nxt_nb;
  reg nxt_nb_valid;
  reg nxt_last;
  reg [1:0] nxt_spd;
  reg [6:0] nxt_hcnt;
  reg nxt_half;
  reg nxt_prev;
  reg nxt_ready;
  reg crc_clr;
  reg crc_en;
  reg load;
  reg [7:0] ld_byte;
  reg bit_end;
  reg [6:0] half_len;
  wire [15:0] crc_q;

  // carrier edge and downlink pause edge seen after two sync stages
  wire ctick = car_sync_ff[1] & ~car_sync_ff[2];
  wire pause_start = pause_sync_ff[1] & ~pause_sync_ff[2];
  wire ext_field = ext_sync_ff[1];
  wire a106 = (spd_ff == `CFC_SPD_106);
  wire cur_bit = a106 ? sh_ff[0] : sh_ff[7];
  wire sending = (bits_ff != 4'h0);
  wire own = !card_mode && (initiator_ff || active_mode);
  wire take = tx_valid && tx_ready_ff;
  wire manch = half_ff ? ~cur_bit : cur_bit;
  wire [7:0] bit_len = {half_len, 1'b0};
  wire rx_end = ctick && rx_active_ff && (rx_cnt_ff == bit_len - 8'h01);
  wire rx_en = card_mode || !initiator_ff;

  // half bit length follows the latched speed only
  always @* begin
    case (spd_ff)
      `CFC_SPD_106: half_len = `CFC_HALF_106;
      `CFC_SPD_212: half_len = `CFC_HALF_212;
      default: half_len = `CFC_HALF_424;
    endcase
  end

  cfc_crc16 u_crc (
    .clk(clk),
    .rst_n(rst_n),
    .clr(crc_clr),
    .en(crc_en),
    .data_in(nb_ff),
    .crc_ff(crc_q)
  );

  // transmit sequencer: bit timer, byte loader, host intake
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_bits = bits_ff;
    nxt_nb = nb_ff;
    nxt_nb_valid = nb_valid_ff;
    nxt_last = last_ff;
    nxt_spd = spd_ff;
    nxt_hcnt = hcnt_ff;
    nxt_half = half_ff;
    nxt_prev = prev_ff;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    load = 1'b0;
    ld_byte = `CFC_PREAMBLE_BYTE;
    bit_end = 1'b0;
    if (ctick && sending) begin
      if (hcnt_ff == half_len - 7'h01) begin
        nxt_hcnt = 7'h00;
        nxt_half = ~half_ff;
        if (half_ff) begin
          bit_end = 1'b1;
          nxt_bits = bits_ff - 4'h1;
          nxt_prev = cur_bit;
          nxt_sh = a106 ? {1'b0, sh_ff[8:1]} : {sh_ff[7:0], 1'b0};
        end
      end else begin
        nxt_hcnt = hcnt_ff + 7'h01;
      end
    end
    // loading on the last bit edge keeps bytes gapless; a late host stalls on a tick
    if ((bit_end && bits_ff == 4'h1) || (!sending && ctick)) begin
      case (state_ff)
        `CFC_ST_PRE: begin
          load = 1'b1;
          if (cnt_ff < `CFC_PREAMBLE_LEN) begin
            ld_byte = `CFC_PREAMBLE_BYTE;
            nxt_cnt = cnt_ff + 4'h1;
          end else begin
            ld_byte = `CFC_SYNC_HI;
            nxt_state = `CFC_ST_SYNC;
          end
        end
        `CFC_ST_SYNC: begin
          load = 1'b1;
          ld_byte = `CFC_SYNC_LO;
          nxt_state = `CFC_ST_DATA;
        end
        `CFC_ST_SOF: begin
          nxt_sh = {8'h00, ~own}; // start bit: Z for miller, 1 for load modulation
          nxt_bits = 4'h1;
          nxt_hcnt = 7'h00;
          nxt_half = 1'b0;
          nxt_state = `CFC_ST_DATA;
        end
        `CFC_ST_DATA: begin
          if (nb_valid_ff) begin
            load = 1'b1;
            ld_byte = nb_ff;
            crc_en = 1'b1;
            nxt_nb_valid = 1'b0;
          end else if (last_ff) begin
            if (a106) begin
              nxt_state = `CFC_ST_IDLE;
              nxt_last = 1'b0;
            end else begin
              load = 1'b1;
              ld_byte = crc_q[15:8];
              nxt_cnt = 4'h0;
              nxt_state = `CFC_ST_CRC;
            end
          end
        end
        `CFC_ST_CRC: begin
          if (cnt_ff == 4'h0) begin
            load = 1'b1;
            ld_byte = crc_q[7:0];
            nxt_cnt = 4'h1;
          end else begin
            nxt_state = `CFC_ST_IDLE;
            nxt_last = 1'b0;
          end
        end
        default: begin
          nxt_bits = 4'h0;
        end
      endcase
    end
    if (load) begin
      nxt_sh = a106 ? {~^ld_byte, ld_byte} : {1'b0, ld_byte}; // odd parity at 106
      nxt_bits = a106 ? 4'h9 : 4'h8;
      nxt_hcnt = 7'h00;
      nxt_half = 1'b0;
    end
    if (take) begin
      nxt_nb = tx_data;
      nxt_nb_valid = 1'b1;
      nxt_last = tx_last;
    end
    // speed may only change between frames with no downlink in progress
    if (state_ff == `CFC_ST_IDLE && !rx_active_ff) begin
      nxt_spd = speed_sel;
    end
    if (state_ff == `CFC_ST_IDLE && take) begin
      crc_clr = 1'b1;
      nxt_prev = 1'b0;
      nxt_cnt = 4'h0;
      nxt_state = (nxt_spd == `CFC_SPD_106) ? `CFC_ST_SOF : `CFC_ST_PRE;
    end
    if (nxt_state == `CFC_ST_IDLE) begin
      nxt_ready = !initiator_ff || init_field_ff;
    end else begin
      nxt_ready = !nxt_nb_valid && !nxt_last;
    end
  end

  // all state registers and outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      car_sync_ff <= 3'h0;
      pause_sync_ff <= 3'h0;
      ext_sync_ff <= 2'h0;
      state_ff <= `CFC_ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 9'h000;
      bits_ff <= 4'h0;
      nb_ff <= 8'h00;
      nb_valid_ff <= 1'b0;
      last_ff <= 1'b0;
      spd_ff <= `CFC_SPD_106;
      hcnt_ff <= 7'h00;
      half_ff <= 1'b0;
      prev_ff <= 1'b0;
      sc_cnt_ff <= 3'h0;
      sc_ff <= 1'b0;
      idle_cnt_ff <= 10'h000;
      init_field_ff <= 1'b0;
      rx_cnt_ff <= 8'h00;
      rx_sof_ff <= 1'b0;
      rx_seen1_ff <= 1'b0;
      rx_seen2_ff <= 1'b0;
      rx_prev_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      field_on_ff <= 1'b0;
      field_mod_ff <= 1'b0;
      load_mod_ff <= 1'b0;
      level_det_en_ff <= 1'b1;
      initiator_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      rx_bit_ff <= 1'b0;
      rx_bit_valid_ff <= 1'b0;
      rx_active_ff <= 1'b0;
    end else begin
      car_sync_ff <= {car_sync_ff[1:0], carrier_in};
      pause_sync_ff <= {pause_sync_ff[1:0], rx_pause_in};
      ext_sync_ff <= {ext_sync_ff[0], ext_field_in};
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      bits_ff <= nxt_bits;
      nb_ff <= nxt_nb;
      nb_valid_ff <= nxt_nb_valid;
      last_ff <= nxt_last;
      spd_ff <= nxt_spd;
      hcnt_ff <= nxt_hcnt;
      half_ff <= nxt_half;
      prev_ff <= nxt_prev;
      tx_ready_ff <= nxt_ready;
      tx_busy_ff <= (nxt_state != `CFC_ST_IDLE);
      // subcarrier runs free from the carrier so its phase is continuous
      if (ctick) begin
        sc_cnt_ff <= sc_cnt_ff + 3'h1;
        if (sc_cnt_ff == `CFC_SUBC_LAST) begin
          sc_ff <= ~sc_ff;
        end
      end
      // role: initiator only on request, field only after a quiet interval
      initiator_ff <= init_req && !card_mode;
      if (!init_req || card_mode) begin
        idle_cnt_ff <= 10'h000;
        init_field_ff <= 1'b0;
      end else if (ext_field) begin
        idle_cnt_ff <= 10'h000;
      end else if (idle_cnt_ff == IDLE_LIM) begin
        init_field_ff <= 1'b1;
      end else begin
        idle_cnt_ff <= idle_cnt_ff + 10'h001;
      end
      // from the request itself, so the detector is back on the edge the role drops
      level_det_en_ff <= !init_req || card_mode || !init_field_ff;
      field_on_ff <= init_field_ff || (!card_mode && active_mode && !initiator_ff && tx_busy_ff);
      // own field: miller pauses at 106, manchester ask above
      if (own && a106) begin
        field_mod_ff <= sending && (hcnt_ff < {2'b00, half_len[6:2]})
          && (cur_bit ? half_ff : (!half_ff && !prev_ff));
      end else begin
        field_mod_ff <= own && sending && manch;
      end
      // load modulation for passive target and card emulation
      if (own || !sending) begin
        load_mod_ff <= 1'b0;
      end else if (a106) begin
        load_mod_ff <= sc_ff && manch;
      end else if (card_mode && card_type_a) begin
        load_mod_ff <= sc_ff ^ ~cur_bit;
      end else begin
        load_mod_ff <= manch;
      end
      // modified miller downlink: pause in second half means one
      rx_bit_valid_ff <= 1'b0;
      if (!rx_en) begin
        rx_active_ff <= 1'b0;
      end else if (rx_end) begin
        rx_cnt_ff <= 8'h00;
        rx_seen1_ff <= pause_start;
        rx_seen2_ff <= 1'b0;
        if (rx_sof_ff) begin
          rx_sof_ff <= 1'b0;
        end else if (!rx_seen1_ff && !rx_seen2_ff && !rx_prev_ff) begin
          rx_active_ff <= 1'b0; // zero then silence ends the frame
        end else begin
          rx_bit_ff <= rx_seen2_ff;
          rx_bit_valid_ff <= 1'b1;
          rx_prev_ff <= rx_seen2_ff;
        end
      end else if (pause_start && !rx_active_ff) begin
        rx_active_ff <= 1'b1;
        rx_cnt_ff <= {2'b00, half_len[6:1]}; // quarter bit in: pauses land mid-window, not on an edge
        rx_sof_ff <= 1'b1;
        rx_seen1_ff <= 1'b0;
        rx_seen2_ff <= 1'b0;
        rx_prev_ff <= 1'b0;
      end else begin
        if (pause_start && rx_cnt_ff < {1'b0, half_len}) begin
          rx_seen1_ff <= 1'b1;
        end
        if (pause_start && rx_cnt_ff >= {1'b0, half_len}) begin
          rx_seen2_ff <= 1'b1;
        end
        if (ctick && rx_active_ff) begin
          rx_cnt_ff <= rx_cnt_ff + 8'h01;
        end
      end
    end
  end
endmodule // cfc_framer
`default_nettype wire

// [hw/cfc_regs.vh]
`ifndef CFC_REGS_VH
`define CFC_REGS_VH
// manchester-scheme frame head
`define CFC_PREAMBLE_BYTE 8'h00
`define CFC_PREAMBLE_LEN 4'h6
`define CFC_SYNC_HI 8'hB2
`define CFC_SYNC_LO 8'h4D
// crc engine, msb first
`define CFC_CRC_POLY 16'h1021
`define CFC_CRC_INIT 16'h0000
// speed select codes
`define CFC_SPD_106 2'h0
`define CFC_SPD_212 2'h1
`define CFC_SPD_424 2'h2
// half bit periods in carrier cycles (full bits 128/64/32)
`define CFC_HALF_106 7'h40
`define CFC_HALF_212 7'h20
`define CFC_HALF_424 7'h10
// subcarrier is carrier/16: toggle every 8 carrier cycles
`define CFC_SUBC_LAST 3'h7
// idle detect time before the initiator may raise its field
`define CFC_CLK_MHZ 100
`define CFC_IDLE_DETECT_TIME_NS 5000
`define CFC_IDLE_DETECT_CYC ((`CFC_IDLE_DETECT_TIME_NS * `CFC_CLK_MHZ + 999) / 1000)
// transmit states
`define CFC_ST_IDLE 3'h0
`define CFC_ST_SOF 3'h1
`define CFC_ST_PRE 3'h2
`define CFC_ST_SYNC 3'h3
`define CFC_ST_DATA 3'h4
`define CFC_ST_CRC 3'h5
`endif

// [hw/cfc_crc16.v]
`timescale 1ns/1ps
`default_nettype none
`include "cfc_regs.vh"
module cfc_crc16 (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // byte feed
  input wire clr,
  input wire en,
  input wire [7:0] data_in,
  // running remainder
  output reg [15:0] crc_ff
);
  integer i;
  reg [15:0] nxt_crc;
  reg fb;

  // one whole byte per cycle, msb of the byte enters first
  always @* begin
    nxt_crc = crc_ff;
    fb = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      fb = nxt_crc[15] ^ data_in[7 - i];
      nxt_crc = {nxt_crc[14:0], 1'b0} ^ (fb ? `CFC_CRC_POLY : 16'h0000);
    end
  end

  // clear wins so a new frame never inherits an old remainder
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_ff <= `CFC_CRC_INIT;
    end else if (clr) begin
      crc_ff <= `CFC_CRC_INIT;
    end else if (en) begin
      crc_ff <= nxt_crc;
    end
  end
endmodule // cfc_crc16
`default_nettype wire

// [tb/cfc_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module cfc_peer (
  // clock and bench control
  input wire logic clk,
  input wire logic ext_on,
  input wire logic line_in,
  input wire logic [3:0] nbytes,
  input wire logic [8:0] bit_clks,
  // rf side of the block
  output logic carrier,
  output logic ext_field,
  output logic pause
);
  logic [1:0] div_ff;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  int k;
  int j;
  // carrier runs free, one tick per four clocks
  initial begin
    carrier = 1'b0;
    pause = 1'b0;
    div_ff = 2'h0;
  end
  always @(posedge clk) begin
    div_ff <= div_ff + 2'h1;
    carrier <= div_ff[1];
  end
  assign ext_field = ext_on;
  // first rise is mid bit 0 of the preamble, so bit 0 is known zero
  initial begin
    forever begin
      @(posedge line_in);
      sh = 8'h00;
      repeat (bit_clks * 3 / 4) @(posedge clk);
      for (k = 1; k < nbytes * 8; k++) begin
        sh = {sh[6:0], line_in};
        if (k % 8 == 7) got_q.push_back(sh);
        repeat (bit_clks) @(posedge clk);
      end
    end
  end
  // one pause of 16 clocks after a given offset
  task automatic pulse(input int at);
    repeat (at) @(negedge clk);
    pause = 1'b1;
    repeat (16) @(negedge clk);
    pause = 1'b0;
  endtask
  // 2-bit codes per period: 1 pause early, 2 pause late, 0 none
  task automatic downlink(input logic [15:0] syms);
    for (j = 0; j < 8; j++) begin
      case (syms[2*j +: 2])
        2'h1: begin
          pulse(8);
          repeat (104) @(negedge clk);
        end
        2'h2: begin
          pulse(72);
          repeat (40) @(negedge clk);
        end
        default: repeat (128) @(negedge clk);
      endcase
    end
  endtask
endmodule // cfc_peer
`default_nettype wire

// [tb/cfc_framer_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cfc_framer_mon (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // watched pins
  input wire tx_valid,
  input wire tx_ready_ff,
  input wire tx_busy_ff,
  input wire active_mode,
  input wire card_mode,
  input wire init_req,
  input wire ext_field_in,
  input wire field_on_ff,
  input wire load_mod_ff,
  input wire level_det_en_ff,
  input wire initiator_ff,
  input wire rx_bit_valid_ff
);
  int quiet_cnt;
  // quiet clocks on the raw detector pin, saturating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet_cnt <= 0;
    else if (ext_field_in) quiet_cnt <= 0;
    else if (quiet_cnt < 1000) quiet_cnt <= quiet_cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    tx_valid && tx_ready_ff && !tx_busy_ff;
  endsequence
  sequence s_target;
    !initiator_ff && !active_mode && !$past(initiator_ff) && !$past(active_mode);
  endsequence
  // role and field control
  det_target_a: assert property (!initiator_ff |-> level_det_en_ff)
    else $error("detector off in target role");
  role_field_a: assert property (s_target |-> !field_on_ff)
    else $error("own field on as passive target");
  quiet_field_a: assert property ($rose(field_on_ff) && initiator_ff |-> quiet_cnt >= 500)
    else $error("field raised before quiet time");
  init_grant_a: assert property (init_req && !card_mode |=> initiator_ff)
    else $error("initiator role not taken");
  init_only_a: assert property (!init_req |=> !initiator_ff)
    else $error("initiator without request");
  init_load_a: assert property (initiator_ff |-> !load_mod_ff)
    else $error("load modulation as initiator");
  // host byte port and downlink pulses
  ready_drop_a: assert property (tx_valid && tx_ready_ff |=> !tx_ready_ff)
    else $error("ready held after take");
  busy_start_a: assert property (s_take |=> tx_busy_ff)
    else $error("frame not started");
  rx_pulse_a: assert property (rx_bit_valid_ff |=> (!rx_bit_valid_ff) [*8])
    else $error("bit pulses too close");
endmodule // cfc_framer_mon
bind cfc_framer cfc_framer_mon i_mon (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
  .tx_ready_ff(tx_ready_ff), .tx_busy_ff(tx_busy_ff), .active_mode(active_mode),
  .card_mode(card_mode), .init_req(init_req), .ext_field_in(ext_field_in),
  .field_on_ff(field_on_ff), .load_mod_ff(load_mod_ff), .level_det_en_ff(level_det_en_ff),
  .initiator_ff(initiator_ff), .rx_bit_valid_ff(rx_bit_valid_ff));
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cfc_regs.vh"
module tb;
  logic clk, rst_n, tx_valid, tx_last, init_req, ext_on, card_mode, active_mode;
  logic [8:0] bit_clks;
  logic [7:0] tx_data;
  logic [1:0] speed_sel;
  logic [3:0] nbytes;
  wire carrier, ext_field, pause, tx_ready_ff, field_on_ff, field_mod_ff, load_mod_ff;
  wire level_det_en_ff, initiator_ff, tx_busy_ff, rx_bit_ff, rx_bit_valid_ff, rx_active_ff;
  int error_cnt = 0;
  int compares = 0;
  logic rxq[$];
  cfc_framer i_dut (.clk(clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready_ff(tx_ready_ff), .speed_sel(speed_sel), .card_mode(card_mode),
    .card_type_a(1'b0), .active_mode(active_mode), .init_req(init_req), .carrier_in(carrier),
    .ext_field_in(ext_field), .rx_pause_in(pause), .field_on_ff(field_on_ff),
    .field_mod_ff(field_mod_ff), .load_mod_ff(load_mod_ff), .level_det_en_ff(level_det_en_ff),
    .initiator_ff(initiator_ff), .tx_busy_ff(tx_busy_ff), .rx_bit_ff(rx_bit_ff),
    .rx_bit_valid_ff(rx_bit_valid_ff), .rx_active_ff(rx_active_ff));
  cfc_peer i_peer (.clk(clk), .ext_on(ext_on), .line_in(field_mod_ff | load_mod_ff),
    .nbytes(nbytes), .bit_clks(bit_clks), .carrier(carrier), .ext_field(ext_field), .pause(pause));
  // downlink bits as they come
  always @(posedge clk) if (rx_bit_valid_ff === 1'b1) rxq.push_back(rx_bit_ff);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // msb-first crc, zero preset by the caller
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  // offer one byte and hold it until the take edge
  task automatic put(input logic [7:0] b, input logic last);
    int n;
    @(negedge clk);
    tx_data = b;
    tx_last = last;
    tx_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tx_ready_ff !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      error_cnt++;
      test_done;
    end
  endtask
  task automatic t_reset;
    check(field_on_ff, 1'b0);
    check(initiator_ff, 1'b0);
    check(level_det_en_ff, 1'b1);
    check(tx_ready_ff, 1'b1);
    check(tx_busy_ff, 1'b0);
    $display("reset test done");
  endtask
  // a stray field in the quiet wait must restart the count
  task automatic t_init;
    int n;
    @(negedge clk);
    ext_on = 1'b1;
    init_req = 1'b1;
    repeat (700) @(negedge clk);
    check(initiator_ff, 1'b1);
    check(field_on_ff, 1'b0);
    check(tx_ready_ff, 1'b0);
    ext_on = 1'b0;
    repeat (300) @(negedge clk);
    ext_on = 1'b1;
    repeat (3) @(negedge clk);
    ext_on = 1'b0;
    n = 0;
    while (field_on_ff !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(n >= 500 && n <= 510, 1'b1);
    if (n >= 1000) test_done;
    $display("initiator test done");
  endtask
  // whole frame: head, length, data, crc, read back by the peer
  task automatic t_frame(input logic [7:0] d[$], input logic fld);
    logic [7:0] exp[$];
    logic [15:0] c;
    int n;
    c = 16'h0000;
    exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hB2, 8'h4D};
    d.push_front(8'(d.size() + 1));
    foreach (d[i]) begin
      c = crc_step(c, d[i]);
      exp.push_back(d[i]);
    end
    exp.push_back(c[15:8]);
    exp.push_back(c[7:0]);
    nbytes = 4'(exp.size());
    i_peer.got_q.delete();
    foreach (d[i]) put(d[i], i == d.size() - 1);
    @(negedge clk);
    tx_valid = 1'b0;
    check(field_on_ff, fld);
    check(tx_ready_ff, 1'b0);
    check(tx_busy_ff, 1'b1);
    n = 0;
    while (tx_busy_ff !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) begin
      error_cnt++;
      test_done;
    end
    check(8'(i_peer.got_q.size()), 8'(exp.size()));
    foreach (exp[i]) check(i_peer.got_q[i], exp[i]);
    $display("frame test done");
  endtask
  // passive target answers by load modulation, own field stays off
  task automatic t_target;
    @(negedge clk);
    init_req = 1'b0;
    repeat (4) @(negedge clk);
    check(initiator_ff, 1'b0);
    t_frame('{8'h5A}, 1'b0);
    check(field_on_ff, 1'b0);
    $display("target test done");
  endtask
  // sof, then 1 0 0 1 0 and a silent period ending the frame
  task automatic t_rx;
    logic [4:0] eb;
    eb = 5'b10010;
    rxq.delete();
    i_peer.downlink(16'h0249);
    repeat (200) @(negedge clk);
    check(8'(rxq.size()), 8'h05);
    foreach (eb[i]) check(rxq[4 - i], eb[i]);
    check(rx_active_ff, 1'b0);
    $display("downlink test done");
  endtask
  // active target raises its own field only while it sends
  task automatic t_active;
    @(negedge clk);
    active_mode = 1'b1;
    t_frame('{8'h11}, 1'b1);
    repeat (2) @(negedge clk);
    check(field_on_ff, 1'b0);
    active_mode = 1'b0;
    $display("active target test done");
  endtask
  // card emulation answers by manchester load modulation
  task automatic t_card;
    @(negedge clk);
    card_mode = 1'b1;
    t_frame('{8'h22}, 1'b0);
    check(initiator_ff, 1'b0);
    @(negedge clk);
    card_mode = 1'b0;
    $display("card test done");
  endtask
  // slower manchester-scheme speed, changed only between frames
  task automatic t_slow;
    @(negedge clk);
    speed_sel = `CFC_SPD_212;
    bit_clks = 9'h100;
    t_frame('{8'h3C}, 1'b0);
    $display("slow speed test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    tx_valid = 1'b0;
    tx_last = 1'b0;
    tx_data = 8'h00;
    init_req = 1'b0;
    ext_on = 1'b0;
    nbytes = 4'h0;
    card_mode = 1'b0;
    active_mode = 1'b0;
    bit_clks = 9'h080;
    speed_sel = `CFC_SPD_424;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset;
    t_init;
    t_frame('{8'hAB, 8'hCD}, 1'b1);
    t_target;
    t_rx;
    t_active;
    t_card;
    t_slow;
    test_done;
  end
endmodule // tb
`default_nettype wire
